// >>> hdl/cdac_top.sv
`include "cdac_map.svh"

// Control and data registers for the current-output converter.
module cdac_top (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [9:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [9:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [3:0] timer_overflow,
   input wire logic external_convert_strobe,
   output cdac_pkg::cdac_out_s dac_out,
   output logic pin_analog_connect,
   output logic pin_digital_enable
);

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic [7:0] dac_control; // Enable, mode and range.
   logic [7:0] dac_code_high; // Upper eight code bits.
   logic [7:0] dac_code_low; // Lower two code bits in bits 7:6.
   logic [9:0] code_latch; // Code driven to the converter.
   logic [31:0] rdata; // Read data register.

   // ----------------------------------------
   // Write channel capture
   // ----------------------------------------
   logic aw_held; // Write address is stored.
   logic w_held; // Write data is stored.
   logic [9:0] aw_addr; // Stored write byte address.
   logic [7:0] w_data; // Stored low byte of write data.
   logic w_lane; // Stored strobe for byte lane zero.

   // Accept each channel when its holding slot is empty.
   // Both slots stay closed while an answer waits, so one write at most is under way.
   assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
   assign s_axi_wready = ~w_held & ~s_axi_bvalid;
   assign s_axi_bresp = 2'h0;
   assign s_axi_rresp = 2'h0;
   assign s_axi_arready = ~s_axi_rvalid;
   assign s_axi_rdata = rdata;

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   // A byte address hits a register when it equals four times the word index.
   // An address that is not word aligned hits nothing, so such an access is ignored.
   function automatic logic addr_hits(input logic [9:0] addr, input logic [7:0] index);
      return addr == {index, 2'h0};
   endfunction : addr_hits

   wire aw_fire = s_axi_awvalid & s_axi_awready; // Address taken.
   wire w_fire = s_axi_wvalid & s_axi_wready; // Data taken.
   wire do_write = aw_held & w_held; // Both halves present.
   wire wr_byte = do_write & w_lane; // Lane zero carries the byte.
   wire wr_ctrl = wr_byte & addr_hits(aw_addr, `CDAC_OFS_CONTROL); // Control register write.
   wire wr_high = wr_byte & addr_hits(aw_addr, `CDAC_OFS_CODE_HIGH); // High data register write.
   wire wr_low = wr_byte & addr_hits(aw_addr, `CDAC_OFS_CODE_LOW); // Low data register write.
   wire update; // Latch update event.

   // Hold address and data until both have arrived.
   // The two channels may come in either order, so each has its own slot.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         // Reset empties both slots and drops any pending answer.
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 10'h000;
         w_data <= 8'h00;
         w_lane <= 1'b0;
         s_axi_bvalid <= 1'b0;
      end else if (ce) begin
         // Address slot: fill on a taken address, empty once the write is done.
         if (aw_fire) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end else if (do_write) begin
            aw_held <= 1'b0;
         end
         // Data slot: only byte lane zero matters to these registers.
         if (w_fire) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata[7:0];
            w_lane <= s_axi_wstrb[0];
         end else if (do_write) begin
            w_held <= 1'b0;
         end
         // The answer rises with the register write and stays until taken.
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
         end else if (s_axi_bready) begin
            // The master has taken the answer.
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Register storage
   // ----------------------------------------
   // Software writes; bits 3:2 of control stay zero.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         dac_control <= `CDAC_CONTROL_RST;
         dac_code_high <= `CDAC_CODE_HIGH_RST;
         dac_code_low <= `CDAC_CODE_LOW_RST;
      end else if (ce) begin
         // Control: the mask keeps the two reserved bits at zero.
         if (wr_ctrl) begin
            dac_control <= w_data & `CDAC_CONTROL_WMASK;
         end
         // High byte: all eight bits are stored as written.
         if (wr_high) begin
            dac_code_high <= w_data;
         end
         // Low byte: only the two code bits are kept, the rest read zero.
         if (wr_low) begin
            dac_code_low <= w_data & `CDAC_LOW_WMASK;
         end
      end
   end

   // ----------------------------------------
   // Trigger selection
   // ----------------------------------------
   // The trigger block synchronises the strobe pin and picks the event for the mode.
   cdac_trigger u_trigger (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .mode(cdac_pkg::cdac_mode_e'(dac_control[`CDAC_MODE_HI:`CDAC_MODE_LO])),
      .timer_overflow(timer_overflow),
      .high_write(wr_high),
      .external_convert_strobe(external_convert_strobe),
      .update(update)
   );

   // The latch copies held registers on the chosen event; for on-demand
   // mode the fresh high byte is taken from the write itself.
   wire [7:0] high_src = wr_high ? w_data : dac_code_high;

   // Copy held data into the converter latch.
   // Outside on-demand mode, data writes alone never reach the output, which keeps timed updates free of jitter.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         // The converter starts at zero current.
         code_latch <= 10'h000;
      end else if (ce && update) begin
         // Left-justified: high byte on top, low byte bits 7:6 below.
         code_latch <= {high_src, dac_code_low[7:6]};
      end
   end

   // ----------------------------------------
   // Outputs to the analog section and pin
   // ----------------------------------------
   // The enable bit hands the pin over to the current output and turns off its
   // digital driver; while it is low the pin is an ordinary port pin.
   assign dac_out.converter_enable = dac_control[`CDAC_EN_BIT];
   assign dac_out.full_scale_select = dac_control[`CDAC_RANGE_HI:`CDAC_RANGE_LO];
   assign dac_out.code = code_latch;
   assign pin_analog_connect = dac_control[`CDAC_EN_BIT];
   assign pin_digital_enable = ~dac_control[`CDAC_EN_BIT];

   // ----------------------------------------
   // Read channel
   // ----------------------------------------
   // Read decode; an address that hits nothing returns zero.
   wire rd_ctrl = addr_hits(s_axi_araddr, `CDAC_OFS_CONTROL); // Control register read.
   wire rd_high = addr_hits(s_axi_araddr, `CDAC_OFS_CODE_HIGH); // High data register read.
   wire rd_low = addr_hits(s_axi_araddr, `CDAC_OFS_CODE_LOW); // Low data register read.
   wire rd_stat = addr_hits(s_axi_araddr, `CDAC_OFS_STATUS); // Latched code read.
   wire [31:0] rd_mux = rd_ctrl ? {24'h000000, dac_control} :
                        rd_high ? {24'h000000, dac_code_high} :
                        rd_low ? {24'h000000, dac_code_low} :
                        rd_stat ? {22'h000000, code_latch} : 32'h00000000;

   // Capture read data when an address is taken.
   // The data is frozen in a register so it cannot move while the answer waits.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         // No answer is pending after reset.
         s_axi_rvalid <= 1'b0;
         rdata <= 32'h00000000;
      end else if (ce) begin
         // A taken address loads the data and raises the answer.
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            rdata <= rd_mux;
         end else if (s_axi_rready) begin
            // The master has taken the answer.
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule : cdac_top

// >>> hdl/cdac_map.svh
// Contract
// - High data register holds code bits nine to two.
// - Low register bits seven,six give code bits one,zero.
// - Control bits one,zero select full-scale current.
// - Range 1x is 2mA, 01 1mA, 00 half mA.
// - Reset range selects 2 mA.
// - Control at 0xB9, reset 0x72, bits three,two zero.
// - High data register read/write, resets zero.
// - Enable connects pin to output, else GPIO.
// - Mode 111 latches both on high write.
// - Modes 000-011 latch on timer overflow.
// - Modes 100-110 latch on strobe edges.
`ifndef CDAC_MAP_SVH
`define CDAC_MAP_SVH

// ----------------------------------------
// Register word indexes; the byte address is four times the index
// ----------------------------------------
`define CDAC_OFS_CONTROL 8'hB9
`define CDAC_OFS_CODE_HIGH 8'hBC
`define CDAC_OFS_CODE_LOW 8'hBD
`define CDAC_OFS_STATUS 8'hC0

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define CDAC_EN_BIT 7
`define CDAC_MODE_HI 6
`define CDAC_MODE_LO 4
`define CDAC_RANGE_HI 1
`define CDAC_RANGE_LO 0
`define CDAC_CONTROL_RST 8'h72
`define CDAC_CONTROL_WMASK 8'hF3
`define CDAC_CODE_HIGH_RST 8'h00
`define CDAC_CODE_LOW_RST 8'h00
`define CDAC_LOW_WMASK 8'hC0

`endif

// >>> hdl/cdac_pkg.sv
package cdac_pkg;

   // ----------------------------------------
   // Update trigger modes
   // ----------------------------------------
   typedef enum logic [2:0] {
      CDAC_UPD_TMR0 = 3'h0,
      CDAC_UPD_TMR1 = 3'h1,
      CDAC_UPD_TMR2 = 3'h2,
      CDAC_UPD_TMR3 = 3'h3,
      CDAC_UPD_RISE = 3'h4,
      CDAC_UPD_FALL = 3'h5,
      CDAC_UPD_BOTH = 3'h6,
      CDAC_UPD_WRITE = 3'h7
   } cdac_mode_e;

   // Output bundle to the analog current source.
   typedef struct packed {
      logic converter_enable;
      logic [1:0] full_scale_select;
      logic [9:0] code;
   } cdac_out_s;

endpackage : cdac_pkg

// >>> hdl/cdac_trigger.sv
`include "cdac_map.svh"

// Picks the update event for the current trigger mode.
module cdac_trigger (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire cdac_pkg::cdac_mode_e mode,
   input wire logic [3:0] timer_overflow,
   input wire logic high_write,
   input wire logic external_convert_strobe,
   output logic update
);

   // ----------------------------------------
   // Strobe synchroniser and edge detect
   // ----------------------------------------
   logic strobe_meta; // First stage, read only by the second.
   logic strobe_sync; // Second stage.
   logic strobe_prev; // Delayed copy for edge detection.

   // Two flip-flops then one delay stage for the pin strobe.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         strobe_meta <= 1'b0;
         strobe_sync <= 1'b0;
         strobe_prev <= 1'b0;
      end else if (ce) begin
         strobe_meta <= external_convert_strobe;
         strobe_sync <= strobe_meta;
         strobe_prev <= strobe_sync;
      end
   end

   wire rise = strobe_sync & ~strobe_prev; // Rising edge seen.
   wire fall = ~strobe_sync & strobe_prev; // Falling edge seen.

   // Mode decode into one update pulse.
   always_comb begin
      unique case (mode)
         cdac_pkg::CDAC_UPD_TMR0: update = timer_overflow[0];
         cdac_pkg::CDAC_UPD_TMR1: update = timer_overflow[1];
         cdac_pkg::CDAC_UPD_TMR2: update = timer_overflow[2];
         cdac_pkg::CDAC_UPD_TMR3: update = timer_overflow[3];
         cdac_pkg::CDAC_UPD_RISE: update = rise;
         cdac_pkg::CDAC_UPD_FALL: update = fall;
         cdac_pkg::CDAC_UPD_BOTH: update = rise | fall;
         cdac_pkg::CDAC_UPD_WRITE: update = high_write;
      endcase
   end

endmodule : cdac_trigger

// >>> bench/cdac_assertions.sv
// ----------------------------------------
// Port checks for the converter registers
// ----------------------------------------
module cdac_assertions (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [3:0] timer_overflow,
   input wire logic external_convert_strobe,
   input wire cdac_pkg::cdac_out_s dac_out,
   input wire logic pin_analog_connect,
   input wire logic pin_digital_enable
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Recent strobe levels, so a synchronised edge still counts as a cause.
   logic [5:0] strobe_hist;
   always_ff @(posedge clk) begin
      strobe_hist <= {strobe_hist[4:0], external_convert_strobe};
   end
   wire strobe_moved = (strobe_hist != 6'h00) && (strobe_hist != 6'h3F);
   // Both write channels taken at one edge.
   sequence s_write_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   a_pin_follows_enable: assert property (pin_analog_connect == dac_out.converter_enable
      && pin_digital_enable == !dac_out.converter_enable) else $error("pin mode wrong");
   a_reset_range: assert property ($rose(rst_n) |-> dac_out.full_scale_select == 2'h2
      && !dac_out.converter_enable) else $error("reset range wrong");
   a_code_cause: assert property (!$stable(dac_out.code) |-> $past(|timer_overflow)
      || $rose(s_axi_bvalid) || strobe_moved) else $error("code moved without cause");
   a_range_by_write: assert property (!$stable(dac_out.full_scale_select) |-> $rose(s_axi_bvalid))
      else $error("range moved without write");
   a_write_answer: assert property (s_write_taken |-> ##2 s_axi_bvalid) else $error("write answer late");
   a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write answer dropped");
   a_write_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken during answer");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped");
   a_read_ends: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
      else $error("read answer stuck");
endmodule : cdac_assertions

bind cdac_top cdac_assertions i_cdac_assertions (.clk, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
   .s_axi_rdata, .timer_overflow, .external_convert_strobe, .dac_out, .pin_analog_connect, .pin_digital_enable);

// >>> bench/testbench.sv
`include "cdac_map.svh"

module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // Signals, rows and counters
   // ----------------------------------------
   logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, external_convert_strobe = 1'b0;
   logic [9:0] s_axi_awaddr = 10'h000, s_axi_araddr = 10'h000;
   logic [7:0] hi = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, got;
   logic [3:0] s_axi_wstrb = 4'h1, timer_overflow = 4'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, pin_analog_connect, pin_digital_enable;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [9:0] exp_code = 10'h000;
   cdac_pkg::cdac_out_s dac_out;
   int fails = 0, checked = 0;
   // Rows hold address, value written and value read back.
   logic [23:0] rows [5] = '{24'hB9FFF3, 24'hBCA5A5, 24'hBDFFC0, 24'h105A00, 24'hB97171};
   always #2 clk = ~clk;
   cdac_top i_cdac_top (.clk, .rst_n, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timer_overflow,
      .external_convert_strobe, .dac_out, .pin_analog_connect, .pin_digital_enable);
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         fails++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // Write one byte; both channels are offered together and held until taken.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      s_axi_awaddr <= {a, 2'h0};
      s_axi_wdata <= {24'h000000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      chk("bresp", 32'h0, 32'(s_axi_bresp));
      if (a == `CDAC_OFS_CODE_HIGH) hi = d;
      @(posedge clk);
   endtask : wr
   // Read one word into got.
   task automatic rd(input logic [7:0] a);
      s_axi_araddr <= {a, 2'h0};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      got = s_axi_rdata;
      chk("rresp", 32'h0, 32'(s_axi_rresp));
      s_axi_rready <= 1'b0;
      @(posedge clk);
   endtask : rd
   // Compare the latch, moving the expectation first when an update is due.
   task automatic code_is(input logic upd);
      if (upd) exp_code = {hi, 2'h3};
      chk("code", 32'(exp_code), 32'(dac_out.code));
   endtask : code_is
   task automatic pulse(input logic [3:0] p);
      timer_overflow <= p;
      @(posedge clk);
      timer_overflow <= 4'h0;
      @(posedge clk);
   endtask : pulse
   // The strobe needs two sync stages and a detect stage before the latch moves.
   task automatic edge_to(input logic lvl);
      external_convert_strobe <= lvl;
      repeat (6) @(posedge clk);
   endtask : edge_to
   task automatic report_and_stop;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : report_and_stop
   // ----------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      rd(`CDAC_OFS_CONTROL);
      chk("control", 32'h72, got);
      rd(`CDAC_OFS_CODE_HIGH);
      chk("high", 32'h0, got);
      chk("range", 32'h2, 32'(dac_out.full_scale_select));
      chk("gpio", 32'h1, 32'(pin_digital_enable));
      foreach (rows[i]) begin
         wr(rows[i][23:16], rows[i][15:8]);
         rd(rows[i][23:16]);
         chk("readback", 32'(rows[i][7:0]), got);
      end
      chk("code", 32'h294, 32'(dac_out.code));
      wr(`CDAC_OFS_CODE_HIGH, 8'h80);
      code_is(1'b1);
      for (int r = 0; r < 4; r++) begin
         wr(`CDAC_OFS_CONTROL, {6'h3C, r[1:0]});
         chk("range", 32'(r), 32'(dac_out.full_scale_select));
         chk("analog", 32'h1, 32'({pin_analog_connect, pin_digital_enable} == 2'h2));
      end
      for (int n = 0; n < 4; n++) begin
         wr(`CDAC_OFS_CONTROL, {1'b1, n[2:0], 4'h2});
         wr(`CDAC_OFS_CODE_HIGH, 8'(n * 17 + 15));
         code_is(1'b0);
         pulse(4'h1 << ((n + 1) % 4));
         code_is(1'b0);
         pulse(4'h1 << n);
         code_is(1'b1);
      end
      for (int m = 4; m < 7; m++) begin
         wr(`CDAC_OFS_CONTROL, {1'b1, m[2:0], 4'h2});
         wr(`CDAC_OFS_CODE_HIGH, 8'(m * 3));
         edge_to(1'b1);
         code_is(m != 5);
         wr(`CDAC_OFS_CODE_HIGH, 8'(m * 5));
         edge_to(1'b0);
         code_is(m != 4);
      end
      // Clock enable low freezes the latch through a timer overflow.
      wr(`CDAC_OFS_CONTROL, 8'h82);
      wr(`CDAC_OFS_CODE_HIGH, 8'h3C);
      ce <= 1'b0;
      pulse(4'h1);
      ce <= 1'b1;
      code_is(1'b0);
      pulse(4'h1);
      code_is(1'b1);
      // A reset in mid-run restores every register and clears the latch.
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      chk("code", 32'h0, 32'(dac_out.code));
      chk("enable", 32'h0, 32'(dac_out.converter_enable));
      rd(`CDAC_OFS_CONTROL);
      chk("control", 32'h72, got);
      chk("range", 32'h2, 32'(dac_out.full_scale_select));
      // On-demand mode keeps a low write out of the latch until the high write.
      wr(`CDAC_OFS_CODE_LOW, 8'h7F);
      chk("code", 32'h0, 32'(dac_out.code));
      rd(`CDAC_OFS_CODE_LOW);
      chk("low", 32'h40, got);
      wr(`CDAC_OFS_CODE_HIGH, 8'h11);
      chk("code", 32'h045, 32'(dac_out.code));
      rd(`CDAC_OFS_STATUS);
      chk("status", 32'h045, got);
      report_and_stop();
   end
   initial begin
      repeat (5000) @(posedge clk);
      fails++;
      report_and_stop();
   end
endmodule : testbench
